// file: logic/mhp_bus_if.sv
// Purpose: Pins between the host end and the device end.
// Assumes: Both ends run on the same clock.
// Notes:   Undriven data lines read as the pull-up level.
`timescale 1ns/1ps
`default_nettype none
interface mhp_bus_if;
  logic       bus_style_select;
  logic       addr_latch_strobe;
  logic       data_strobe_n_oe;
  logic       rd_wr_n;
  logic       chip_sel_n;
  logic [7:0] host_ad;
  logic       host_ad_oe_n;
  logic [7:0] dev_ad;
  logic       dev_ad_oe_n;
  logic [7:0] muxed_addr_data;

  // Wire level from the two output enables
  assign muxed_addr_data = !dev_ad_oe_n  ? dev_ad  :
                           !host_ad_oe_n ? host_ad : mhp_pkg::BUS_IDLE;

  modport dev (
    input  bus_style_select, addr_latch_strobe, data_strobe_n_oe,
    input  rd_wr_n, chip_sel_n, muxed_addr_data,
    output dev_ad, dev_ad_oe_n
  );
  modport host (
    output bus_style_select, addr_latch_strobe, data_strobe_n_oe,
    output rd_wr_n, chip_sel_n, host_ad, host_ad_oe_n,
    input  muxed_addr_data
  );
endinterface
`default_nettype wire

// file: logic/mhp_dev_end.sv
// Purpose: Device end of the muxed host bus port.
// Assumes: All bus pins asynchronous; two-stage synchroniser on each.
// Notes:   Strobe edges are seen two clocks after the pins move.
`timescale 1ns/1ps
`default_nettype none
module mhp_dev_end #(
  parameter int unsigned RECOV_CYC = mhp_pkg::RECOV_CYC
) (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  mhp_bus_if.dev          bus,
  input  wire logic       power_fail_i,
  input  wire logic       host_rst_n_i,
  input  wire logic [7:0] acc_rdata_i,
  output logic      [7:0] acc_addr_o,
  output logic      [7:0] acc_wdata_o,
  output logic            acc_wr_o,
  output logic            acc_rd_o,
  output logic            access_blocked_o
);
  localparam int RW = $clog2(RECOV_CYC + 1);

  logic [14:0]        pin_vec;
  logic [14:0]        s1_reg;
  logic [14:0]        s1_next;
  logic [14:0]        s2_reg;
  logic [14:0]        s2_next;
  logic [14:0]        prv_reg;
  logic [14:0]        prv_next;
  logic               style_s;
  logic               as_s;
  logic               ds_s;
  logic               rw_s;
  logic               csn_s;
  logic               pf_s;
  logic               hrn_s;
  logic [7:0]         ad_s;
  logic               as_fall;
  logic               as_rise;
  logic               ds_fall;
  logic               ds_rise;
  logic               we_rise;
  logic               wr_edge;
  logic               rd_on;
  logic               cyc_end;
  logic               sel;
  logic [7:0]         addr_reg;
  logic [7:0]         addr_next;
  logic               vld_reg;
  logic               vld_next;
  logic [RW-1:0]      rec_reg;
  logic [RW-1:0]      rec_next;
  logic               blk_reg;
  logic               blk_next;
  mhp_pkg::mhp_dst_t  st_reg;
  mhp_pkg::mhp_dst_t  st_next;
  logic [7:0]         dout_reg;
  logic [7:0]         dout_next;
  logic               oe_n_reg;
  logic               oe_n_next;
  logic               rd_reg;
  logic               rd_next;
  logic               wr_reg;
  logic               wr_next;
  logic [7:0]         wdat_reg;
  logic [7:0]         wdat_next;

  // Raw pins, gathered for the synchroniser
  assign pin_vec = {bus.bus_style_select, bus.addr_latch_strobe,
                    bus.data_strobe_n_oe, bus.rd_wr_n, bus.chip_sel_n,
                    power_fail_i, host_rst_n_i, bus.muxed_addr_data};

  // Two stages, then a third copy for edge detection
  always_comb begin
    s1_next  = pin_vec;
    s2_next  = s1_reg;
    prv_next = s2_reg;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_reg  <= mhp_pkg::PIN_RST;
      s2_reg  <= mhp_pkg::PIN_RST;
      prv_reg <= mhp_pkg::PIN_RST;
    end else begin
      s1_reg  <= s1_next;
      s2_reg  <= s2_next;
      prv_reg <= prv_next;
    end
  end

  // Synchronised pin levels; data lines move with the strobes
  assign style_s = s2_reg[14];
  assign as_s    = s2_reg[13];
  assign ds_s    = s2_reg[12];
  assign rw_s    = s2_reg[11];
  assign csn_s   = s2_reg[10];
  assign pf_s    = s2_reg[9];
  assign hrn_s   = s2_reg[8];
  assign ad_s    = s2_reg[7:0];

  // Edges of the strobes
  assign as_fall = prv_reg[13] & ~as_s;
  assign as_rise = ~prv_reg[13] & as_s;
  assign ds_fall = prv_reg[12] & ~ds_s;
  assign ds_rise = ~prv_reg[12] & ds_s;
  assign we_rise = ~prv_reg[11] & rw_s;

  // Write edge, read window and end of data phase per style
  assign wr_edge = style_s ? (ds_fall & ~rw_s) : we_rise;
  assign rd_on   = style_s ? (ds_s & rw_s) : (~ds_s & rw_s);
  assign cyc_end = style_s ? ds_fall : (ds_rise | we_rise);

  // Internal select: pin gated by power fail, reset and recovery
  assign sel = ~csn_s & ~blk_reg;

  // Address latch; one access per strobe so a new one is needed
  always_comb begin
    addr_next = addr_reg;
    vld_next  = vld_reg;
    if (as_fall) begin
      addr_next = ad_s;
      vld_next  = 1'b1;
    end else if (as_rise || cyc_end) begin
      vld_next  = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      addr_reg <= 8'h00;
      vld_reg  <= 1'b0;
    end else begin
      addr_reg <= addr_next;
      vld_reg  <= vld_next;
    end
  end

  // Blocking: reloads while supply low, counts down after
  always_comb begin
    rec_next = rec_reg;
    if (pf_s) begin
      rec_next = RW'(RECOV_CYC);
    end else if (rec_reg != '0) begin
      rec_next = rec_reg - 1'b1;
    end
    blk_next = pf_s | ~hrn_s | (rec_reg != '0);
  end

  // Blocked after reset until the pins have been sampled
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rec_reg <= '0;
      blk_reg <= 1'b1;
    end else begin
      rec_reg <= rec_next;
      blk_reg <= blk_next;
    end
  end

  // Read sequencing and write capture
  always_comb begin
    st_next   = st_reg;
    dout_next = dout_reg;
    oe_n_next = 1'b1;
    rd_next   = 1'b0;
    wr_next   = 1'b0;
    wdat_next = wdat_reg;
    if (wr_edge && sel && vld_reg) begin
      wr_next   = 1'b1;
      wdat_next = ad_s;
    end
    unique case (st_reg)
      mhp_pkg::MHP_D_IDLE: begin
        if (rd_on && sel && vld_reg) begin
          rd_next = 1'b1;
          st_next = mhp_pkg::MHP_D_FETCH;
        end
      end
      mhp_pkg::MHP_D_FETCH: begin
        if (rd_on && sel) begin
          dout_next = acc_rdata_i;
          oe_n_next = 1'b0;
          st_next   = mhp_pkg::MHP_D_DRIVE;
        end else begin
          st_next   = mhp_pkg::MHP_D_IDLE;
        end
      end
      mhp_pkg::MHP_D_DRIVE: begin
        // Strobe end or lost select releases the lines at once
        if (rd_on && sel) begin
          oe_n_next = 1'b0;
        end else begin
          st_next   = mhp_pkg::MHP_D_IDLE;
        end
      end
      default: begin
        st_next = mhp_pkg::MHP_D_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg   <= mhp_pkg::MHP_D_IDLE;
      dout_reg <= 8'h00;
      oe_n_reg <= 1'b1;
      rd_reg   <= 1'b0;
      wr_reg   <= 1'b0;
      wdat_reg <= 8'h00;
    end else begin
      st_reg   <= st_next;
      dout_reg <= dout_next;
      oe_n_reg <= oe_n_next;
      rd_reg   <= rd_next;
      wr_reg   <= wr_next;
      wdat_reg <= wdat_next;
    end
  end

  // All outputs straight from flops
  assign bus.dev_ad        = dout_reg;
  assign bus.dev_ad_oe_n   = oe_n_reg;
  assign acc_addr_o        = addr_reg;
  assign acc_wdata_o       = wdat_reg;
  assign acc_wr_o          = wr_reg;
  assign acc_rd_o          = rd_reg;
  assign access_blocked_o  = blk_reg;
endmodule
`default_nettype wire

// file: logic/mhp_host_end.sv
// Purpose: Host end: turns byte commands into muxed bus cycles.
// Assumes: Far end samples pins through a two-stage synchroniser.
// Notes:   One command at a time; strobe widths from package.
`timescale 1ns/1ps
`default_nettype none
module mhp_host_end (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  mhp_bus_if.host         bus,
  input  wire logic       style_i,
  input  wire logic       cmd_valid_i,
  input  wire logic       cmd_write_i,
  input  wire logic [7:0] cmd_addr_i,
  input  wire logic [7:0] cmd_wdata_i,
  output logic            cmd_ready_o,
  output logic            rsp_valid_o,
  output logic      [7:0] rsp_rdata_o
);
  localparam int CW = mhp_pkg::CNT_W;

  mhp_pkg::mhp_hst_t  st_reg;
  mhp_pkg::mhp_hst_t  st_next;
  logic [CW-1:0]      cnt_reg;
  logic [CW-1:0]      cnt_next;
  logic               wr_reg;
  logic               wr_next;
  logic [7:0]         wd_reg;
  logic [7:0]         wd_next;
  logic               sty_reg;
  logic               sty_next;
  logic               as_reg;
  logic               as_next;
  logic               ds_reg;
  logic               ds_next;
  logic               rw_reg;
  logic               rw_next;
  logic               csn_reg;
  logic               csn_next;
  logic [7:0]         ad_reg;
  logic [7:0]         ad_next;
  logic               oen_reg;
  logic               oen_next;
  logic               rdy_reg;
  logic               rdy_next;
  logic               rv_reg;
  logic               rv_next;
  logic [7:0]         rd_reg;
  logic [7:0]         rd_next;
  logic               cnt_zero;

  assign cnt_zero = (cnt_reg == '0);

  // Bus cycle sequencer; style only changes between cycles
  always_comb begin
    st_next  = st_reg;
    cnt_next = cnt_zero ? cnt_reg : cnt_reg - 1'b1;
    wr_next  = wr_reg;
    wd_next  = wd_reg;
    sty_next = sty_reg;
    as_next  = as_reg;
    ds_next  = ds_reg;
    rw_next  = rw_reg;
    csn_next = csn_reg;
    ad_next  = ad_reg;
    oen_next = oen_reg;
    rdy_next = rdy_reg;
    rv_next  = 1'b0;
    rd_next  = rd_reg;
    unique case (st_reg)
      mhp_pkg::MHP_H_IDLE: begin
        sty_next = style_i;
        ds_next  = ~style_i;
        rw_next  = 1'b1;
        if (cmd_valid_i && rdy_reg) begin
          rdy_next = 1'b0;
          wr_next  = cmd_write_i;
          wd_next  = cmd_wdata_i;
          as_next  = 1'b1;
          csn_next = 1'b0;
          ad_next  = cmd_addr_i;
          oen_next = 1'b0;
          rw_next  = style_i ? ~cmd_write_i : 1'b1;
          cnt_next = CW'(mhp_pkg::AS_CYC - 1);
          st_next  = mhp_pkg::MHP_H_ADDR;
        end
      end
      mhp_pkg::MHP_H_ADDR: begin
        if (cnt_zero) begin
          as_next  = 1'b0;
          cnt_next = CW'(mhp_pkg::AHOLD_CYC - 1);
          st_next  = mhp_pkg::MHP_H_AHOLD;
        end
      end
      mhp_pkg::MHP_H_AHOLD: begin
        if (cnt_zero) begin
          ad_next  = wd_reg;
          oen_next = ~wr_reg;
          if (sty_reg) begin
            ds_next = 1'b1;
          end else if (wr_reg) begin
            rw_next = 1'b0;
          end else begin
            ds_next = 1'b0;
          end
          cnt_next = CW'(mhp_pkg::DS_CYC - 1);
          st_next  = mhp_pkg::MHP_H_DATA;
        end
      end
      mhp_pkg::MHP_H_DATA: begin
        if (cnt_zero) begin
          rv_next  = ~wr_reg;
          rd_next  = wr_reg ? rd_reg : bus.muxed_addr_data;
          ds_next  = ~sty_reg;
          rw_next  = sty_reg ? rw_reg : 1'b1;
          cnt_next = CW'(mhp_pkg::GAP_CYC - 1);
          st_next  = mhp_pkg::MHP_H_DONE;
        end
      end
      mhp_pkg::MHP_H_DONE: begin
        // Select and write data held until the far end saw the edge
        if (cnt_zero) begin
          csn_next = 1'b1;
          oen_next = 1'b1;
          rw_next  = 1'b1;
          rdy_next = 1'b1;
          st_next  = mhp_pkg::MHP_H_IDLE;
        end
      end
      default: begin
        st_next = mhp_pkg::MHP_H_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg  <= mhp_pkg::MHP_H_IDLE;
      cnt_reg <= '0;
      wr_reg  <= 1'b0;
      wd_reg  <= 8'h00;
      sty_reg <= 1'b0;
      as_reg  <= 1'b0;
      ds_reg  <= 1'b1;
      rw_reg  <= 1'b1;
      csn_reg <= 1'b1;
      ad_reg  <= 8'h00;
      oen_reg <= 1'b1;
      rdy_reg <= 1'b1;
      rv_reg  <= 1'b0;
      rd_reg  <= 8'h00;
    end else begin
      st_reg  <= st_next;
      cnt_reg <= cnt_next;
      wr_reg  <= wr_next;
      wd_reg  <= wd_next;
      sty_reg <= sty_next;
      as_reg  <= as_next;
      ds_reg  <= ds_next;
      rw_reg  <= rw_next;
      csn_reg <= csn_next;
      ad_reg  <= ad_next;
      oen_reg <= oen_next;
      rdy_reg <= rdy_next;
      rv_reg  <= rv_next;
      rd_reg  <= rd_next;
    end
  end

  // Pins and user side from flops
  assign bus.bus_style_select  = sty_reg;
  assign bus.addr_latch_strobe = as_reg;
  assign bus.data_strobe_n_oe  = ds_reg;
  assign bus.rd_wr_n           = rw_reg;
  assign bus.chip_sel_n        = csn_reg;
  assign bus.host_ad           = ad_reg;
  assign bus.host_ad_oe_n      = oen_reg;
  assign cmd_ready_o           = rdy_reg;
  assign rsp_valid_o           = rv_reg;
  assign rsp_rdata_o           = rd_reg;
endmodule
`default_nettype wire

// file: logic/mhp_pkg.sv
// Purpose: Shared constants and types for the muxed host bus port.
// Assumes: 100 MHz clock on both ends.
// Notes:   Times in ns or us; cycle counts derive from them, except AHOLD_CYC.
package mhp_pkg;
  localparam int CLK_MHZ = 100;
  localparam int AD_W    = 8;
  // Level seen on the shared lines when nobody drives them
  localparam logic [7:0] BUS_IDLE = 8'hFF;
  // Host access held off after supply recovers
  localparam int RECOV_US  = 20000;
  localparam int RECOV_CYC = RECOV_US * CLK_MHZ;
  // Host strobe timing, least times rounded up
  localparam int AS_NS   = 60;
  localparam int AS_CYC  = (AS_NS * CLK_MHZ + 999) / 1000;
  localparam int DS_NS   = 125;
  localparam int DS_CYC  = (DS_NS * CLK_MHZ + 999) / 1000;
  localparam int GAP_NS  = 150;
  localparam int GAP_CYC = (GAP_NS * CLK_MHZ + 999) / 1000;
  // Address hold after strobe fall; covers the far synchroniser
  localparam int AHOLD_CYC = 4;
  localparam int CNT_W     = 5;
  // Reset value of the synchronised pin vector
  localparam logic [14:0] PIN_RST = 15'h0000;

  typedef enum logic [1:0] {
    MHP_D_IDLE  = 2'b00,
    MHP_D_FETCH = 2'b01,
    MHP_D_DRIVE = 2'b11
  } mhp_dst_t;

  typedef enum logic [2:0] {
    MHP_H_IDLE  = 3'b000,
    MHP_H_ADDR  = 3'b001,
    MHP_H_AHOLD = 3'b011,
    MHP_H_DATA  = 3'b010,
    MHP_H_DONE  = 3'b110
  } mhp_hst_t;
endpackage

// file: verification/mhp_checker.sv
// Purpose: Bus-level checks on the link joining host and device ends.
// Assumes: One clock; instantiated by the bench beside the interface.
// Notes:   Sees only interface signals, so access pulses are judged by
//          the bench.
`timescale 1ns/1ps
`default_nettype none
module mhp_checker (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       bus_style_select,
  input  wire logic       addr_latch_strobe,
  input  wire logic       data_strobe_n_oe,
  input  wire logic       rd_wr_n,
  input  wire logic       chip_sel_n,
  input  wire logic       host_ad_oe_n,
  input  wire logic       dev_ad_oe_n,
  input  wire logic [7:0] muxed_addr_data
);
  logic       rd_win;
  logic       phase;
  logic [4:0] as_gap_reg;
  logic [4:0] as_gap_next;
  logic [4:0] shut_reg;
  logic [4:0] shut_next;

  // Read window and data phase, as the style pin defines them
  assign rd_win = rd_wr_n && (bus_style_select == data_strobe_n_oe);
  assign phase  = bus_style_select ? data_strobe_n_oe
                                   : (!data_strobe_n_oe || !rd_wr_n);

  // Saturating ages: since address strobe, since read window closed
  always_comb begin
    as_gap_next = addr_latch_strobe ? 5'h00
                : as_gap_reg + {4'h0, as_gap_reg != 5'h1F};
    shut_next   = rd_win ? 5'h00 : shut_reg + {4'h0, shut_reg != 5'h1F};
  end

  // Start saturated so nothing looks recent after reset
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      as_gap_reg <= 5'h1F;
      shut_reg   <= 5'h1F;
    end else begin
      as_gap_reg <= as_gap_next;
      shut_reg   <= shut_next;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_no_bus_fight: assert property (
    !(!dev_ad_oe_n && !host_ad_oe_n)) else $error("both ends drive bus");
  a_drive_in_window: assert property (
    $fell(dev_ad_oe_n) |-> rd_win && $past(rd_win, 4))
    else $error("device drove outside read window");
  a_release_in_time: assert property (
    shut_reg >= 5'h06 |-> dev_ad_oe_n) else $error("bus not released");
  a_drive_needs_sel: assert property (
    !dev_ad_oe_n |-> !chip_sel_n) else $error("drive while deselected");
  a_sel_over_strobes: assert property (
    $stable(bus_style_select) && (phase || addr_latch_strobe)
    |-> !chip_sel_n) else $error("select dropped during strobe");
  a_as_before_phase: assert property (
    $rose(phase) && $stable(bus_style_select) |-> as_gap_reg <= 5'h08)
    else $error("data phase without fresh address strobe");
  a_as_width: assert property (
    $rose(addr_latch_strobe) |-> addr_latch_strobe [*6] ##1
    !addr_latch_strobe) else $error("address strobe width wrong");
  a_addr_hold: assert property (
    $fell(addr_latch_strobe) |-> $stable(muxed_addr_data) [*4])
    else $error("address moved at strobe fall");
  a_rw_steady: assert property (
    bus_style_select && data_strobe_n_oe && $past(data_strobe_n_oe)
    |-> $stable(rd_wr_n)) else $error("read/write moved in strobe");
endmodule
`default_nettype wire

// file: verification/muxed_host_bus_port_tb.sv
// Purpose: Self-checking bench joining host end and device end.
// Assumes: 100 MHz clock; inputs change on the falling edge.
// Notes:   A second device is driven by hand to break host rules.
`timescale 1ns/1ps
`default_nettype none
module muxed_host_bus_port_tb;
  localparam int unsigned RECOV = 50;
  logic       clk, rst_n, pf, hrst_n, style, vld, wr, rdy, rsp_v;
  logic       acc_wr, acc_rd, blocked, wr_b;
  logic [7:0] caddr, cwdata, rdata, addr, wdata, addr_b, wdata_b;
  logic [7:0] rsp_data, rsp_seen, last_waddr, last_wdata;
  int         error_cnt = 0;
  int         compares = 0;
  int         wr_cnt = 0;
  int         rd_cnt = 0;
  int         wr_b_cnt = 0;

  mhp_bus_if bus_a ();
  mhp_bus_if bus_b ();

  mhp_host_end u_mhp_host_end (.clk_i(clk), .rst_n_i(rst_n), .bus(bus_a),
    .style_i(style), .cmd_valid_i(vld), .cmd_write_i(wr),
    .cmd_addr_i(caddr), .cmd_wdata_i(cwdata), .cmd_ready_o(rdy),
    .rsp_valid_o(rsp_v), .rsp_rdata_o(rsp_data));
  mhp_dev_end #(.RECOV_CYC(RECOV)) u_mhp_dev_end (.clk_i(clk),
    .rst_n_i(rst_n), .bus(bus_a), .power_fail_i(pf),
    .host_rst_n_i(hrst_n), .acc_rdata_i(rdata), .acc_addr_o(addr),
    .acc_wdata_o(wdata), .acc_wr_o(acc_wr), .acc_rd_o(acc_rd),
    .access_blocked_o(blocked));
  mhp_dev_end #(.RECOV_CYC(RECOV)) u_mhp_dev_end_b (.clk_i(clk),
    .rst_n_i(rst_n), .bus(bus_b), .power_fail_i(1'b0),
    .host_rst_n_i(1'b1), .acc_rdata_i(8'h00), .acc_addr_o(addr_b),
    .acc_wdata_o(wdata_b), .acc_wr_o(wr_b), .acc_rd_o(),
    .access_blocked_o());
  mhp_checker u_mhp_checker (.clk_i(clk), .rst_n_i(rst_n),
    .bus_style_select(bus_a.bus_style_select),
    .addr_latch_strobe(bus_a.addr_latch_strobe),
    .data_strobe_n_oe(bus_a.data_strobe_n_oe),
    .rd_wr_n(bus_a.rd_wr_n), .chip_sel_n(bus_a.chip_sel_n),
    .host_ad_oe_n(bus_a.host_ad_oe_n), .dev_ad_oe_n(bus_a.dev_ad_oe_n),
    .muxed_addr_data(bus_a.muxed_addr_data));

  // Clock, 10 ns period
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Memory behind the device: data is the address with a fixed mask
  always @(negedge clk) rdata <= addr ^ 8'h5A;

  // Count access pulses and keep what they carried
  always @(posedge clk) begin
    if (acc_wr === 1'b1) begin
      wr_cnt++;
      last_waddr = addr;
      last_wdata = wdata;
    end
    if (acc_rd === 1'b1) rd_cnt++;
    if (rsp_v === 1'b1) rsp_seen = rsp_data;
    if (wr_b === 1'b1) wr_b_cnt++;
  end

  task automatic tally_and_finish();
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string what);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Bounded wait for the host end to come idle
  task automatic wait_rdy();
    int n;
    n = 0;
    while (rdy !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    if (rdy !== 1'b1) begin
      error_cnt++;
      $display("[ERR] %0t host never ready", $time);
      tally_and_finish();
    end
  endtask

  // One command; held a single edge while ready is high
  task automatic cmd(input logic w, input logic [7:0] a,
                     input logic [7:0] d);
    wait_rdy();
    vld = 1'b1;
    wr = w;
    caddr = a;
    cwdata = d;
    @(negedge clk);
    vld = 1'b0;
    repeat (2) @(negedge clk);
    wait_rdy();
  endtask

  // Hand-driven level-style cycle on the second device; re_as raises
  // the address strobe again together with the data strobe
  task automatic b_acc(input logic cs_n, input logic do_as,
                       input logic [7:0] a, input logic [7:0] d,
                       input logic re_as);
    bus_b.chip_sel_n = cs_n;
    bus_b.rd_wr_n = 1'b0;
    bus_b.host_ad_oe_n = 1'b0;
    if (do_as) begin
      bus_b.host_ad = a;
      bus_b.addr_latch_strobe = 1'b1;
      repeat (mhp_pkg::AS_CYC) @(negedge clk);
      bus_b.addr_latch_strobe = 1'b0;
      repeat (mhp_pkg::AHOLD_CYC) @(negedge clk);
    end
    bus_b.addr_latch_strobe = re_as;
    bus_b.host_ad = d;
    bus_b.data_strobe_n_oe = 1'b1;
    repeat (mhp_pkg::DS_CYC) @(negedge clk);
    bus_b.data_strobe_n_oe = 1'b0;
    repeat (mhp_pkg::AHOLD_CYC) @(negedge clk);
    bus_b.rd_wr_n = 1'b1;
    bus_b.chip_sel_n = 1'b1;
    bus_b.host_ad_oe_n = 1'b1;
    bus_b.addr_latch_strobe = 1'b0;
    repeat (mhp_pkg::GAP_CYC) @(negedge clk);
  endtask

  // Write then two back-to-back reads in the given style
  task automatic t_rw(input logic s);
    logic [7:0] a;
    int         w0;
    int         r0;
    a = s ? 8'h3C : 8'h0E;
    style = s;
    repeat (4) @(negedge clk);
    w0 = wr_cnt;
    r0 = rd_cnt;
    cmd(1'b1, a, ~a);
    chk(8'(wr_cnt - w0), 8'h01, "write count");
    chk(last_waddr, a, "write address");
    chk(last_wdata, ~a, "write data");
    cmd(1'b0, a, 8'h00);
    chk(rsp_seen, a ^ 8'h5A, "read data");
    cmd(1'b0, a + 8'h01, 8'h00);
    chk(rsp_seen, (a + 8'h01) ^ 8'h5A, "second read");
    chk(8'(rd_cnt - r0), 8'h02, "read count");
    chk(8'(wr_cnt - w0), 8'h01, "reads seen as writes");
    $display("test rw style %0d done", s);
  endtask

  // Power fail blocks, then recovery hold-off before access returns
  task automatic t_pf();
    int w0;
    int n;
    pf = 1'b1;
    repeat (6) @(negedge clk);
    chk({7'h00, blocked}, 8'h01, "blocked in power fail");
    w0 = wr_cnt;
    cmd(1'b1, 8'h21, 8'h9E);
    chk(8'(wr_cnt - w0), 8'h00, "write in power fail");
    pf = 1'b0;
    n = 0;
    while (blocked === 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    chk({7'h00, n >= RECOV && n <= RECOV + 8}, 8'h01, "recovery");
    cmd(1'b1, 8'h21, 8'h9E);
    chk(8'(wr_cnt - w0), 8'h01, "write after recovery");
    $display("test power fail done");
  endtask

  // Reset pin refuses access, no hold-off once released
  task automatic t_hrst();
    int r0;
    hrst_n = 1'b0;
    repeat (6) @(negedge clk);
    chk({7'h00, blocked}, 8'h01, "blocked in reset");
    r0 = rd_cnt;
    cmd(1'b0, 8'h05, 8'h00);
    chk(8'(rd_cnt - r0), 8'h00, "read in reset");
    chk(rsp_seen, mhp_pkg::BUS_IDLE, "bus idle in reset");
    hrst_n = 1'b1;
    repeat (6) @(negedge clk);
    chk({7'h00, blocked}, 8'h00, "blocked after reset");
    cmd(1'b0, 8'h05, 8'h00);
    chk(rsp_seen, 8'h5F, "read after reset");
    $display("test reset pin done");
  endtask

  // Deselected cycle latches only; no-strobe access is refused
  task automatic t_desel();
    b_acc(1'b1, 1'b1, 8'h44, 8'h99, 1'b0);
    chk(addr_b, 8'h44, "deselected address");
    chk(8'(wr_b_cnt), 8'h00, "deselected write");
    b_acc(1'b0, 1'b0, 8'h00, 8'h77, 1'b0);
    chk(8'(wr_b_cnt), 8'h00, "write without strobe");
    b_acc(1'b0, 1'b1, 8'h45, 8'h78, 1'b0);
    chk(8'(wr_b_cnt), 8'h01, "selected write");
    chk(wdata_b, 8'h78, "selected data");
    chk(addr_b, 8'h45, "selected address");
    // Strobe rising again with the data strobe leaves no address
    b_acc(1'b0, 1'b1, 8'h46, 8'h79, 1'b1);
    chk(8'(wr_b_cnt), 8'h01, "strobe rise drops address");
    $display("test deselect done");
  endtask

  // Main sequence
  initial begin
    rst_n = 1'b0;
    pf = 1'b0;
    hrst_n = 1'b1;
    style = 1'b0;
    vld = 1'b0;
    wr = 1'b0;
    caddr = 8'h00;
    cwdata = 8'h00;
    bus_b.bus_style_select = 1'b1;
    bus_b.addr_latch_strobe = 1'b0;
    bus_b.data_strobe_n_oe = 1'b0;
    bus_b.rd_wr_n = 1'b1;
    bus_b.chip_sel_n = 1'b1;
    bus_b.host_ad = 8'h00;
    bus_b.host_ad_oe_n = 1'b1;
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    repeat (6) @(negedge clk);
    t_rw(1'b0);
    t_rw(1'b1);
    t_pf();
    t_hrst();
    t_desel();
    tally_and_finish();
  end
endmodule
`default_nettype wire
